// [design/cts_hard_err.v]
// Purpose: Formats the hard-error byte for the recording format in use.
// Assumes: Flag inputs are already synchronous to aclk.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "cts_map.vh"

module cts_hard_err (
   // Format select.
   input wire nrz_mode,
   // Phase-encoded and group-coded flags.
   input wire ident_found_flag,
   input wire corrected_error_flag,
   input wire vertical_parity_error_flag,
   input wire skew_error_flag,
   input wire multi_track_error_flag,
   input wire false_postamble_flag,
   input wire false_preamble_flag,
   // NRZ flags.
   input wire longitudinal_check_error_flag,
   input wire cyclic_check_error_flag,
   // Formatted byte.
   output reg [7:0] hard_error_byte
);

   // ------------------------------------------------------------
   // Layout selection
   // ------------------------------------------------------------

   // NRZ marks bit 7 and leaves bits 6..3 clear; otherwise seven flags.
   always @* begin
      if (nrz_mode) begin
         hard_error_byte = {`CTS_NRZ_MARK, 4'h0,
            longitudinal_check_error_flag, cyclic_check_error_flag,
            vertical_parity_error_flag};
      end else begin
         hard_error_byte = {`CTS_PE_MARK, ident_found_flag,
            corrected_error_flag, vertical_parity_error_flag,
            skew_error_flag, multi_track_error_flag,
            false_postamble_flag, false_preamble_flag};
      end
   end

endmodule

// [design/cts_map.vh]
// Purpose: Offsets, field positions and reset values of the condensed
//          tape status register bank.
// Assumes: Registers are word aligned on a 32-bit AXI4-Lite bus.
// Notes:   Summary of operation follows.
//
// Summary of operation
// - Density code into density byte bits 7:6.
// - Copy end-of-tape-limit flag into bit 5.
// - Copy early end-of-tape flag into bit 4.
// - Copy available-density flags into bits 3:0.
// - Bits 3..0 mean 6250, 800, 3200, 1600 bpi.
// - PE/GCR hard-error byte: bit7 zero, seven flags.
// - NRZ hard-error byte: bit7 one, three check flags.
// - Extra byte: glitch bit 4, gap bit 3.
// - Density-source code into extra byte bits 7:6.
`ifndef CTS_MAP_VH
`define CTS_MAP_VH

// ------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ------------------------------------------------------------
`define CTS_OFF_WR_ERR 4'h0
`define CTS_OFF_RD_ERR 4'h1
`define CTS_OFF_DIAG_PROG 4'h2
`define CTS_OFF_DIAG_ERR 4'h3
`define CTS_OFF_TRACK_ERR 4'h4
`define CTS_OFF_HARD_ERR 4'h5
`define CTS_OFF_SUPP 4'h6
`define CTS_OFF_EXTRA 4'h7
`define CTS_OFF_DENSITY 4'h8
`define CTS_OFF_CTRL 4'h9
`define CTS_OFF_STATUS 4'hA
`define CTS_NUM_REGS 11

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTS_SUPP_EOT_LIMIT 5
`define CTS_SUPP_EARLY_EOT 4
`define CTS_CTRL_FREEZE 0
`define CTS_CTRL_REFRESH 1
`define CTS_NRZ_MARK 1'b1
`define CTS_PE_MARK 1'b0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CTS_BYTE_RST 8'h00
`define CTS_RESP_OKAY 2'b00
`define CTS_RESP_SLVERR 2'b10

`endif

// [design/cts_regs.v]
// Purpose: Condensed tape status bytes, read over AXI4-Lite.
// Assumes: Full status bytes come from tape logic on another clock
//          and pass two flip-flops before use.
// Notes:   Writing freeze holds a snapshot; refresh loads one now.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cts_map.vh"

module cts_regs (
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address.
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data.
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response.
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address.
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data.
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Full status bytes from the tape unit.
   input wire [7:0] write_error_log,
   input wire [7:0] read_error_log,
   input wire [7:0] diag_program_number,
   input wire [7:0] diag_error_code,
   input wire [7:0] track_error_flags,
   input wire [7:0] hard_error_flags,
   input wire [7:0] supplementary_status_byte,
   input wire [7:0] condition_status_byte,
   input wire [7:0] density_origin_status_byte,
   input wire [7:0] identification_status_byte,
   // Format flags and the NRZ-only error flags.
   input wire nrz_mode,
   input wire longitudinal_check_error_flag,
   input wire cyclic_check_error_flag,
   // Snapshot state for local use.
   output reg frozen
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------

   // Packed raw inputs: 10 bytes plus 3 flags.
   localparam W = 83;
   wire [W-1:0] raw;
   reg [W-1:0] sync1_q;
   reg [W-1:0] sync2_q;
   assign raw = {write_error_log, read_error_log, diag_program_number,
      diag_error_code, track_error_flags, hard_error_flags,
      supplementary_status_byte, condition_status_byte,
      density_origin_status_byte, identification_status_byte,
      nrz_mode, longitudinal_check_error_flag, cyclic_check_error_flag};

   // Two stages; only the second stage is read by logic.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= {W{1'b0}};
         sync2_q <= {W{1'b0}};
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   // Named views of the synchronised status.
   wire [7:0] s_wr = sync2_q[82:75];
   wire [7:0] s_rd = sync2_q[74:67];
   wire [7:0] s_dp = sync2_q[66:59];
   wire [7:0] s_de = sync2_q[58:51];
   wire [7:0] s_te = sync2_q[50:43];
   wire [7:0] s_he = sync2_q[42:35];
   wire [7:0] s_sup = sync2_q[34:27];
   wire [7:0] s_cond = sync2_q[26:19];
   wire [7:0] s_orig = sync2_q[18:11];
   wire [7:0] s_ident = sync2_q[10:3];
   wire s_nrz = sync2_q[2];
   wire s_lrc = sync2_q[1];
   wire s_crc = sync2_q[0];

   // ------------------------------------------------------------
   // Byte formatting
   // ------------------------------------------------------------

   // Hard-error byte, laid out per recording format.
   wire [7:0] hard_fmt;
   cts_hard_err u_hard (
      .nrz_mode(s_nrz),
      .ident_found_flag(s_he[6]),
      .corrected_error_flag(s_he[5]),
      .vertical_parity_error_flag(s_he[4]),
      .skew_error_flag(s_he[3]),
      .multi_track_error_flag(s_he[2]),
      .false_postamble_flag(s_he[1]),
      .false_preamble_flag(s_he[0]),
      .longitudinal_check_error_flag(s_lrc),
      .cyclic_check_error_flag(s_crc),
      .hard_error_byte(hard_fmt)
   );

   // Supplementary condition byte collects flags from two sources.
   wire [7:0] supp_fmt = {s_cond[7], s_sup[6], s_sup[7], s_cond[4],
      s_sup[3], s_sup[2], s_sup[1], s_cond[0]};

   // Extra byte: density source, glitch, gap, mismatch, parity.
   wire [7:0] extra_fmt = {s_orig[7:6],
      1'b0, s_cond[2], s_cond[1],
      1'b0, s_orig[1], s_sup[0]};

   // Density byte: selected code, end-of-tape flags, available set.
   // Available bits 3..0 are 6250, 800, 3200 and 1600 bpi.
   wire [7:0] dens_fmt = {s_ident[7:6],
      s_sup[`CTS_SUPP_EOT_LIMIT],
      s_sup[`CTS_SUPP_EARLY_EOT],
      s_ident[3:0]};

   // ------------------------------------------------------------
   // Snapshot registers
   // ------------------------------------------------------------

   reg [7:0] byte_q [0:8]; // Condensed bytes presented to software.
   reg freeze_q; // Holds the snapshot while set.
   reg refresh_q; // One-cycle request to load a snapshot.
   reg [7:0] snap_cnt_q; // Counts snapshots taken.
   wire [7:0] fmt [0:8];
   assign fmt[0] = s_wr;
   assign fmt[1] = s_rd;
   assign fmt[2] = {1'b0, s_dp[6:0]};
   assign fmt[3] = s_de;
   assign fmt[4] = s_te;
   assign fmt[5] = hard_fmt;
   assign fmt[6] = supp_fmt;
   assign fmt[7] = extra_fmt;
   assign fmt[8] = dens_fmt;

   wire load = !freeze_q || refresh_q;

   // Every byte loads together, so fields never disagree with each other.
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1) begin : g_byte
         always @(posedge aclk) begin
            if (!aresetn) begin
               byte_q[gi] <= `CTS_BYTE_RST;
            end else if (load) begin
               byte_q[gi] <= fmt[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------

   reg aw_have_q; // Write address captured.
   reg w_have_q; // Write data captured.
   reg [3:0] aw_idx_q;
   reg aw_ok_q;
   reg [31:0] wdata_q;
   reg wstrb0_q;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   // Accept address and data in either order; answer once both held.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CTS_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_idx_q <= 4'h0;
         aw_ok_q <= 1'b0;
         wdata_q <= 32'h00000000;
         wstrb0_q <= 1'b0;
         freeze_q <= 1'b0;
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= 1'b0;
         s_axi_awready <= !aw_have_q && !aw_fire && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !w_fire && !s_axi_bvalid;
         if (aw_fire) begin
            aw_have_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[5:2];
            aw_ok_q <= (s_axi_awaddr[31:6] == 26'h0000000);
         end
         if (w_fire) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            // Only the control register is writable; others are refused.
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_ok_q && (aw_idx_q == `CTS_OFF_CTRL)) begin
               s_axi_bresp <= `CTS_RESP_OKAY;
               if (wstrb0_q) begin
                  freeze_q <= wdata_q[`CTS_CTRL_FREEZE];
                  refresh_q <= wdata_q[`CTS_CTRL_REFRESH];
               end
            end else begin
               s_axi_bresp <= `CTS_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Snapshot counter and status output
   // ------------------------------------------------------------

   // Counts each refresh request, frozen or not; shows as status.
   always @(posedge aclk) begin
      if (!aresetn) begin
         snap_cnt_q <= 8'h00;
         frozen <= 1'b0;
      end else begin
         frozen <= freeze_q;
         if (refresh_q) begin
            snap_cnt_q <= snap_cnt_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------

   reg [31:0] rd_mux;
   reg rd_ok;

   // Decode the read address to a word; unmapped answers SLVERR.
   always @* begin
      rd_mux = 32'h00000000;
      rd_ok = (s_axi_araddr[31:6] == 26'h0000000);
      if (s_axi_araddr[5:2] <= `CTS_OFF_DENSITY) begin
         rd_mux = {24'h000000, byte_q[s_axi_araddr[5:2]]};
      end else if (s_axi_araddr[5:2] == `CTS_OFF_CTRL) begin
         rd_mux = {30'h00000000, 1'b0, freeze_q};
      end else if (s_axi_araddr[5:2] == `CTS_OFF_STATUS) begin
         rd_mux = {23'h000000, freeze_q, snap_cnt_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   // One read in flight; data appears the cycle after address taken.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CTS_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_mux : 32'h00000000;
            s_axi_rresp <= rd_ok ? `CTS_RESP_OKAY : `CTS_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// [verification/cts_host.sv]
// Purpose: Host that reads sense bytes over AXI4-Lite.
// Assumes: One request at a time, held until taken.
// Notes:   Released address lines show the inverted address.
`timescale 1ns/1ps
module cts_host (
   // Clock.
   input wire logic aclk,
   // Write channels.
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels.
   output logic [31:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero.
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // Read: address until taken, rready until data arrives.
   task rd(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Write: each of address and data released when taken.
   task wr(input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_awready) s_axi_awaddr <= ~a;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_wready) s_axi_wdata <= ~d;
      end while ((s_axi_awvalid && !s_axi_awready) ||
         (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
endmodule

// [verification/cts_regs_props.sv]
// Purpose: Assertions on condensed status bytes returned by reads.
// Assumes: Status inputs hold for five clocks before a checked read.
// Notes:   Bound to cts_regs by name.
`timescale 1ns/1ps
module cts_regs_props (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Read channels.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // Status sources and snapshot state.
   input wire logic [7:0] hard_error_flags,
   input wire logic [7:0] supplementary_status_byte,
   input wire logic [7:0] condition_status_byte,
   input wire logic [7:0] density_origin_status_byte,
   input wire logic [7:0] identification_status_byte,
   input wire logic nrz_mode,
   input wire logic longitudinal_check_error_flag,
   input wire logic cyclic_check_error_flag,
   input wire logic frozen
);
   wire [7:0] rd = s_axi_rdata[7:0]; // Byte lane of read data.
   wire [7:0] sp = supplementary_status_byte;
   wire [7:0] id = identification_status_byte;
   wire [7:0] cn = condition_status_byte;
   wire [42:0] cur = {hard_error_flags, sp, cn, id, nrz_mode,
      density_origin_status_byte, longitudinal_check_error_flag,
      cyclic_check_error_flag};
   logic [42:0] prv_q; // Inputs one clock ago.
   logic [2:0] stab_q; // Clocks the inputs have held, saturating.
   logic [7:0] ra_q; // Address of the read under way.
   // A read is only judged once the sync chain has settled.
   wire ok = !frozen && stab_q >= 3'h5 && s_axi_rresp == 2'h0;

   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   // Counts quiet clocks and keeps the accepted read address.
   always @(posedge aclk) begin
      prv_q <= cur;
      if (cur !== prv_q) begin
         stab_q <= 3'h0;
      end else if (stab_q != 3'h7) begin
         stab_q <= stab_q + 3'h1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         ra_q <= s_axi_araddr[7:0];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property got(a, e);
      $rose(s_axi_rvalid) && ok && ra_q == a |-> e;
   endproperty
   dens_sel_a: assert property (got(8'h20, rd[7:6] == id[7:6]))
      else $error("density code wrong");
   eot_lim_a: assert property (got(8'h20, rd[5] == sp[5]))
      else $error("end limit bit wrong");
   early_eot_a: assert property (got(8'h20, rd[4] == sp[4]))
      else $error("early end bit wrong");
   dens_avail_a: assert property (got(8'h20, rd[3:0] == id[3:0]))
      else $error("available densities wrong");
   hard_pe_a: assert property (got(8'h14, nrz_mode ||
      rd == {1'b0, hard_error_flags[6:0]})) else $error("pe byte wrong");
   hard_nrz_a: assert property (got(8'h14, !nrz_mode ||
      rd == {5'h10, longitudinal_check_error_flag,
      cyclic_check_error_flag, hard_error_flags[4]}))
      else $error("nrz byte wrong");
   glitch_gap_a: assert property (got(8'h1C, rd[4:3] == cn[2:1]))
      else $error("glitch or gap bit wrong");
   dens_src_a: assert property (got(8'h1C,
      rd[7:6] == density_origin_status_byte[7:6]))
      else $error("density source wrong");
   cover property (got(8'h14, nrz_mode));
   cover property (got(8'h20, 1'b1));
   cover property ($rose(frozen));
endmodule

bind cts_regs cts_regs_props u_props (.*);

// [verification/tb_condensed_tape_status_bytes.sv]
// Purpose: Self-checking bench for the condensed status bytes.
// Assumes: Host model drives the bus; bench drives status inputs.
// Notes:   Expected results queue up; a monitor compares them.
`timescale 1ns/1ps
module tb_condensed_tape_status_bytes;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [95:0] st = '0; // Every full status input, in one vector.
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, frozen;
   wire [7:0] write_error_log = st[7:0];
   wire [7:0] read_error_log = st[15:8];
   wire [7:0] diag_program_number = st[23:16];
   wire [7:0] diag_error_code = st[31:24];
   wire [7:0] track_error_flags = st[39:32];
   wire [7:0] hard_error_flags = st[47:40];
   wire [7:0] supplementary_status_byte = st[55:48];
   wire [7:0] condition_status_byte = st[63:56];
   wire [7:0] density_origin_status_byte = st[71:64];
   wire [7:0] identification_status_byte = st[79:72];
   wire nrz_mode = st[80];
   wire longitudinal_check_error_flag = st[81];
   wire cyclic_check_error_flag = st[82];
   logic [33:0] expq[$]; // Expected {resp, data} in issue order.
   int n_errors = 0;
   int check_count = 0;
   int i;
   int k;
   logic [95:0] r;
   logic [7:0] old;

   cts_regs dut (.*);
   cts_host host (.*);

   // 10 MHz clock.
   initial forever #50 aclk = ~aclk;

   // Expected condensed byte at word index q.
   function logic [7:0] eb(input int q);
      logic [7:0] h, s, c, o, d;
      h = hard_error_flags;
      s = supplementary_status_byte;
      c = condition_status_byte;
      o = density_origin_status_byte;
      d = identification_status_byte;
      case (q)
         0: eb = write_error_log;
         1: eb = read_error_log;
         2: eb = {1'b0, diag_program_number[6:0]};
         3: eb = diag_error_code;
         4: eb = track_error_flags;
         5: eb = nrz_mode ? {5'h10, longitudinal_check_error_flag,
            cyclic_check_error_flag, h[4]} : {1'b0, h[6:0]};
         6: eb = {c[7], s[6], s[7], c[4], s[3:1], c[0]};
         7: eb = {o[7:6], 1'b0, c[2:1], 1'b0, o[1], s[0]};
         default: eb = {d[7:6], s[5:4], d[3:0]};
      endcase
   endfunction

   // Compares one value and counts the result.
   task chk(input logic [33:0] got, input logic [33:0] e);
      check_count++;
      if (got !== e) begin
         n_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, e);
      end
   endtask

   // Notes the expected byte, then reads it.
   task rdx(input int q);
      expq.push_back({26'h0, eb(q)});
      host.rd(q * 4);
   endtask

   // Prints the counts and the verdict, then stops.
   task close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Monitor: each response is compared with the oldest note.
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
      end else if (s_axi_bvalid && s_axi_bready) begin
         chk({s_axi_bresp, 32'h0}, expq.pop_front());
      end
   end

   // Watchdog against a hung handshake.
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'hEE63));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Random status, both formats, every byte read.
      for (i = 0; i < 24; i++) begin
         r = {$urandom, $urandom, $urandom};
         r[80] = i[0];
         st <= r;
         repeat (5) @(posedge aclk);
         for (k = 0; k < 9; k++) rdx(k);
      end
      $display("test copy done");
      // Unmapped reads and a write to a read-only byte are refused.
      expq.push_back({2'h2, 32'h0});
      host.rd(32'h2C);
      expq.push_back({2'h2, 32'h0});
      host.rd(32'h1020);
      expq.push_back({2'h2, 32'h0});
      host.wr(32'h20, 32'hFF, 4'hF);
      rdx(8);
      $display("test refuse done");
      // Frozen bytes hold until a refresh loads new ones.
      expq.push_back(34'h0);
      host.wr(32'h24, 32'h1, 4'hF);
      repeat (2) @(posedge aclk);
      chk({33'h0, frozen}, 34'h1);
      // A control write without the low byte lane changes nothing.
      expq.push_back(34'h0);
      host.wr(32'h24, 32'h0, 4'hE);
      repeat (2) @(posedge aclk);
      chk({33'h0, frozen}, 34'h1);
      old = eb(8);
      st <= ~st;
      repeat (5) @(posedge aclk);
      expq.push_back({26'h0, old});
      host.rd(32'h20);
      expq.push_back(34'h0);
      host.wr(32'h24, 32'h3, 4'hF);
      repeat (2) @(posedge aclk);
      rdx(8);
      // Status shows freeze set and one snapshot; control shows freeze.
      expq.push_back({2'h0, 32'h101});
      host.rd(32'h28);
      expq.push_back({2'h0, 32'h1});
      host.rd(32'h24);
      expq.push_back(34'h0);
      host.wr(32'h24, 32'h0, 4'hF);
      repeat (5) @(posedge aclk);
      rdx(8);
      $display("test freeze done");
      close_out();
   end
endmodule
